// ==== core/tps_defines.svh ====
`ifndef TPS_DEFINES_SVH
`define TPS_DEFINES_SVH
// Register byte offsets
`define TPS_OFF_CTRL 12'h240
`define TPS_OFF_STAT 12'h244
`define TPS_OFF_FLAGS 12'h248
`define TPS_OFF_ENA 12'h24C
`define TPS_OFF_CFG 12'h250
// Control register fields
`define TPS_CTRL_FLUSH 16
`define TPS_CTRL_RETRY 7:0
`define TPS_RETRY_MAX_RST 8'hFF
// Configuration register fields
`define TPS_CFG_FLUSH_EN 0
// Event flag positions
`define TPS_FLG_ASY 27
`define TPS_FLG_LOST 26
`define TPS_FLG_RCVD 25
`define TPS_FLG_ISO 24
`define TPS_FLG_FLSH0 23
`define TPS_FLG_IMPL 32'h0F800000
// First quadlet fields
`define TPS_Q_NODE 21:16
`define TPS_Q_PACKET_IDENTIFIER 15:8
`define TPS_Q_TCODE 7:4
// Acknowledge and packet codes
`define TPS_ACK_COMPLETE 4'h1
`define TPS_ACK_PENDING 4'h2
`define TPS_ACK_BUSY_X 4'h4
`define TPS_ACK_BUSY_A 4'h5
`define TPS_ACK_BUSY_B 4'h6
`define TPS_TCODE_STREAM 4'hA
`define TPS_NODE_BROADCAST 6'h3F
// Sizes
`define TPS_ACK_DEPTH 7
`define TPS_ACK_DEPTH_MAX 7
`define TPS_VID_MAX_PATHS 2
`endif

// ==== core/tps_pkg.sv ====
package tps_pkg;
    typedef struct packed {
        logic [11:0] address;
        logic read;
        logic write;
        logic [31:0] writedata;
        logic [3:0] byteenable;
    } tps_avs_req_t;

    typedef struct packed {
        logic ack_valid;
        logic [3:0] ack_code;
        logic ack_pop;
        logic pkt_done;
        logic [31:0] pkt_quadlet;
        logic retry;
        logic async_bad_tcode;
        logic iso_bad_tcode;
        logic iso_len_err;
        logic buf0_err;
        logic [7:0] vid_a_sel;
        logic [7:0] vid_b_sel;
    } tps_engine_t;

    typedef struct packed {
        logic waitreq;
        logic [31:0] rdata;
        logic irq;
        logic flush0;
        logic vid_err;
        logic ack_err;
        logic [3:0] ack_code;
        logic [5:0] node;
        logic [7:0] pkt_id;
        logic [3:0] tcode;
        logic [2:0] ack_cnt;
        logic [31:0] flags;
        logic [31:0] ena;
        logic [7:0] retry_max;
        logic [7:0] retry_cnt;
        logic flush_en;
    } tps_state_t;
endpackage : tps_pkg

// ==== core/tps_tx_status.sv ====
// Design decision made here: register access over Avalon-MM.
`timescale 1ns/1ns
`include "tps_defines.svh"
module tps_tx_status #(
    parameter int ACK_DEPTH = `TPS_ACK_DEPTH
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Avalon-MM slave
    input wire tps_pkg::tps_avs_req_t avs_req,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Transmit engine
    input wire tps_pkg::tps_engine_t eng,
    output logic buf0_flush,
    // Interrupt
    output logic irq
);

    generate
        if (ACK_DEPTH < 1 || ACK_DEPTH > `TPS_ACK_DEPTH_MAX) begin : g_bad_depth
            $error("ACK_DEPTH must lie between 1 and 7");
        end
    endgenerate

    localparam logic [2:0] DEPTH = 3'(ACK_DEPTH);

    tps_pkg::tps_state_t state_reg;
    tps_pkg::tps_state_t state_next;

    logic acc;
    logic rd_flags;
    logic wr_ctrl;
    logic wr_ena;
    logic wr_cfg;
    logic wr_flags;
    logic ack_flush;
    logic vid_cond;
    logic is_stream;
    logic int_ack;
    logic push;
    logic overrun;
    logic give_up;
    logic [3:0] push_code;
    logic [31:0] bmask;
    logic [31:0] sets;
    logic [31:0] clr;

    function automatic logic is_ack_error(input logic [3:0] code);
        is_ack_error = !(code == `TPS_ACK_COMPLETE || code == `TPS_ACK_PENDING
            || code == `TPS_ACK_BUSY_X || code == `TPS_ACK_BUSY_A
            || code == `TPS_ACK_BUSY_B);
    endfunction : is_ack_error

    function automatic logic [3:0] pop_count(input logic [7:0] v);
        logic [3:0] c;
        c = 4'h0;
        for (int i = 0; i < 8; i++) begin
            c = c + {3'h0, v[i]};
        end
        pop_count = c;
    endfunction : pop_count

    function automatic logic [31:0] byte_mask(input logic [3:0] be);
        byte_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction : byte_mask

    // Reserved bits are constant zero in every word
    function automatic logic [31:0] read_word(input logic [11:0] a,
                                              input tps_pkg::tps_state_t s);
        read_word = 32'h0;
        case (a)
            `TPS_OFF_CTRL: read_word = {24'h0, s.retry_max};
            `TPS_OFF_STAT: read_word = {2'h0, s.vid_err, s.ack_err, s.ack_code, 2'h0,
                s.node, s.pkt_id, s.tcode, 1'h0, s.ack_cnt};
            `TPS_OFF_FLAGS: read_word = s.flags & `TPS_FLG_IMPL;
            `TPS_OFF_ENA: read_word = s.ena & `TPS_FLG_IMPL;
            `TPS_OFF_CFG: read_word = {31'h0, s.flush_en};
            default: read_word = 32'h0;
        endcase
    endfunction : read_word

    always_comb begin
        state_next = state_reg;
        acc = (avs_req.read | avs_req.write) & ~state_reg.waitreq;
        bmask = byte_mask(avs_req.byteenable);
        rd_flags = acc & avs_req.read & (avs_req.address == `TPS_OFF_FLAGS);
        wr_ctrl = acc & avs_req.write & (avs_req.address == `TPS_OFF_CTRL);
        wr_ena = acc & avs_req.write & (avs_req.address == `TPS_OFF_ENA);
        wr_cfg = acc & avs_req.write & (avs_req.address == `TPS_OFF_CFG);
        wr_flags = acc & avs_req.write & (avs_req.address == `TPS_OFF_FLAGS);

        // One wait cycle, then the answer for exactly one cycle
        state_next.waitreq = ~((avs_req.read | avs_req.write) & state_reg.waitreq);
        if (avs_req.read && state_reg.waitreq) begin
            state_next.rdata = read_word(avs_req.address, state_reg);
        end

        if (wr_ctrl && avs_req.byteenable[0]) begin
            state_next.retry_max = avs_req.writedata[`TPS_CTRL_RETRY];
        end
        // Flush bit is never stored, so it reads back zero
        ack_flush = wr_ctrl & avs_req.byteenable[2]
            & avs_req.writedata[`TPS_CTRL_FLUSH];
        if (wr_ena) begin
            state_next.ena = ((state_reg.ena & ~bmask) | (avs_req.writedata & bmask))
                & `TPS_FLG_IMPL;
        end
        if (wr_cfg && avs_req.byteenable[0]) begin
            state_next.flush_en = avs_req.writedata[`TPS_CFG_FLUSH_EN];
        end

        vid_cond = (|(eng.vid_a_sel & eng.vid_b_sel))
            || (pop_count(eng.vid_a_sel | eng.vid_b_sel) > 4'(`TPS_VID_MAX_PATHS));
        state_next.vid_err = vid_cond;

        is_stream = (eng.pkt_quadlet[`TPS_Q_TCODE] == `TPS_TCODE_STREAM)
            || (eng.pkt_quadlet[`TPS_Q_NODE] == `TPS_NODE_BROADCAST);
        int_ack = eng.pkt_done & is_stream & ~eng.ack_valid;
        push = eng.ack_valid | int_ack;
        push_code = eng.ack_valid ? eng.ack_code : `TPS_ACK_COMPLETE;
        if (push) begin
            state_next.ack_code = push_code;
            state_next.ack_err = is_ack_error(push_code);
        end
        if (eng.pkt_done) begin
            state_next.node = eng.pkt_quadlet[`TPS_Q_NODE];
            state_next.pkt_id = eng.pkt_quadlet[`TPS_Q_PACKET_IDENTIFIER];
            state_next.tcode = eng.pkt_quadlet[`TPS_Q_TCODE];
        end

        // Entry count; a pop on an empty FIFO is ignored
        overrun = push & ~eng.ack_pop & (state_reg.ack_cnt == DEPTH);
        if (ack_flush) begin
            state_next.ack_cnt = 3'h0;
        end else if (push && !eng.ack_pop && state_reg.ack_cnt != DEPTH) begin
            state_next.ack_cnt = state_reg.ack_cnt + 3'h1;
        end else if (!push && eng.ack_pop && state_reg.ack_cnt != 3'h0) begin
            state_next.ack_cnt = state_reg.ack_cnt - 3'h1;
        end

        give_up = eng.retry & (state_reg.retry_cnt == state_reg.retry_max);
        if (eng.pkt_done) begin
            state_next.retry_cnt = 8'h00;
        end else if (eng.retry && !give_up) begin
            state_next.retry_cnt = state_reg.retry_cnt + 8'h01;
        end

        state_next.flush0 = eng.buf0_err & state_reg.flush_en;

        sets = 32'h0;
        sets[`TPS_FLG_ASY] = (push & is_ack_error(push_code)) | give_up
            | eng.async_bad_tcode;
        sets[`TPS_FLG_LOST] = overrun;
        sets[`TPS_FLG_RCVD] = push;
        sets[`TPS_FLG_ISO] = eng.iso_bad_tcode | eng.iso_len_err;
        sets[`TPS_FLG_FLSH0] = eng.buf0_err & state_reg.flush_en;

        // A read clears only bits already reported, a write the bits written with one; new events win
        clr = 32'h0;
        if (rd_flags) begin
            clr = state_reg.rdata;
        end
        if (wr_flags) begin
            clr = clr | (avs_req.writedata & bmask);
        end
        state_next.flags = ((state_reg.flags & ~clr) | sets) & `TPS_FLG_IMPL;
        state_next.irq = |(state_next.flags & state_next.ena);
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_reg <= '0;
            state_reg.waitreq <= 1'b1;
            state_reg.retry_max <= `TPS_RETRY_MAX_RST;
        end else begin
            state_reg <= state_next;
        end
    end

    assign avs_readdata = state_reg.rdata;
    assign avs_waitrequest = state_reg.waitreq;
    assign buf0_flush = state_reg.flush0;
    assign irq = state_reg.irq;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    a_vid_err_both: assert property ((|(eng.vid_a_sel & eng.vid_b_sel))
        |=> state_reg.vid_err)
        else $error("video selection error not raised");

    a_vid_paths: assert property ($countones(eng.vid_a_sel | eng.vid_b_sel)
        > `TPS_VID_MAX_PATHS |=> state_reg.vid_err)
        else $error("too many video paths not flagged");

    a_vid_err_clear: assert property (!(|(eng.vid_a_sel & eng.vid_b_sel))
        && $countones(eng.vid_a_sel | eng.vid_b_sel) <= `TPS_VID_MAX_PATHS
        |=> !state_reg.vid_err)
        else $error("video selection error without cause");

    a_ack_err_flag: assert property (eng.ack_valid
        && !(eng.ack_code inside {`TPS_ACK_COMPLETE, `TPS_ACK_PENDING,
        `TPS_ACK_BUSY_X, `TPS_ACK_BUSY_A, `TPS_ACK_BUSY_B})
        |=> state_reg.ack_err && state_reg.flags[`TPS_FLG_ASY])
        else $error("error acknowledge not flagged");

    a_ack_ok_clear: assert property (eng.ack_valid
        && eng.ack_code inside {`TPS_ACK_COMPLETE, `TPS_ACK_PENDING,
        `TPS_ACK_BUSY_X, `TPS_ACK_BUSY_A, `TPS_ACK_BUSY_B}
        |=> !state_reg.ack_err)
        else $error("good acknowledge flagged as error");

    a_ack_code_cap: assert property (eng.ack_valid
        |=> state_reg.ack_code == $past(eng.ack_code))
        else $error("acknowledge code not captured");

    a_ack_code_hold: assert property (!eng.ack_valid && !eng.pkt_done
        |=> $stable(state_reg.ack_code))
        else $error("acknowledge code changed without acknowledge");

    a_internal_ack: assert property (eng.pkt_done && !eng.ack_valid
        && (eng.pkt_quadlet[`TPS_Q_TCODE] == `TPS_TCODE_STREAM
        || eng.pkt_quadlet[`TPS_Q_NODE] == `TPS_NODE_BROADCAST)
        |=> state_reg.ack_code == `TPS_ACK_COMPLETE && !state_reg.ack_err
        && state_reg.flags[`TPS_FLG_RCVD])
        else $error("internal ack-complete missing");

    a_packet_fields: assert property (eng.pkt_done
        |=> state_reg.node == $past(eng.pkt_quadlet[`TPS_Q_NODE])
        && state_reg.pkt_id == $past(eng.pkt_quadlet[`TPS_Q_PACKET_IDENTIFIER])
        && state_reg.tcode == $past(eng.pkt_quadlet[`TPS_Q_TCODE]))
        else $error("packet status fields wrong");

    a_packet_hold: assert property (!eng.pkt_done
        |=> $stable(state_reg.node) && $stable(state_reg.pkt_id)
        && $stable(state_reg.tcode))
        else $error("packet status fields changed without a packet");

    a_ack_count_up: assert property (push && !eng.ack_pop && !ack_flush
        && state_reg.ack_cnt < DEPTH
        |=> state_reg.ack_cnt == $past(state_reg.ack_cnt) + 3'h1)
        else $error("acknowledge count not incremented");

    a_ack_count_down: assert property (!push && eng.ack_pop && !ack_flush
        && state_reg.ack_cnt != 3'h0
        |=> state_reg.ack_cnt == $past(state_reg.ack_cnt) - 3'h1)
        else $error("acknowledge count not decremented");

    a_ack_count_hold: assert property (push && eng.ack_pop && !ack_flush
        |=> $stable(state_reg.ack_cnt))
        else $error("acknowledge count moved on push with pop");

    a_ack_count_max: assert property (state_reg.ack_cnt <= DEPTH)
        else $error("acknowledge count beyond FIFO depth");

    a_reserved_zero: assert property (!state_reg.waitreq && avs_req.read
        && avs_req.address == `TPS_OFF_STAT
        |-> avs_readdata[31:30] == 2'h0 && avs_readdata[23:22] == 2'h0
        && avs_readdata[3] == 1'b0)
        else $error("reserved status bits not zero");

    a_flag_reserved: assert property ((state_reg.flags & ~`TPS_FLG_IMPL) == 32'h0
        && (state_reg.ena & ~`TPS_FLG_IMPL) == 32'h0)
        else $error("reserved flag or enable bit set");

    a_enable_write: assert property (wr_ena && avs_req.byteenable == 4'hF
        |=> state_reg.ena == ($past(avs_req.writedata) & `TPS_FLG_IMPL))
        else $error("enable register write not taken");

    a_async_bad_code: assert property (eng.async_bad_tcode
        |=> state_reg.flags[`TPS_FLG_ASY])
        else $error("illegal async code not flagged");

    a_overrun_flag: assert property (overrun |=> state_reg.flags[`TPS_FLG_LOST])
        else $error("acknowledge overrun not flagged");

    a_overrun_hold: assert property (overrun && !ack_flush
        |=> state_reg.ack_cnt == DEPTH)
        else $error("acknowledge count moved on overrun");

    a_rcvd_flag: assert property (eng.ack_valid |=> state_reg.flags[`TPS_FLG_RCVD])
        else $error("acknowledge received not flagged");

    a_rcvd_irq: assert property (state_reg.flags[`TPS_FLG_RCVD]
        && state_reg.ena[`TPS_FLG_RCVD] |-> irq)
        else $error("enabled acknowledge received without interrupt");

    a_irq_level: assert property (irq == (|(state_reg.flags & state_reg.ena)))
        else $error("interrupt does not follow enabled flags");

    a_iso_err_flag: assert property (eng.iso_len_err
        |=> state_reg.flags[`TPS_FLG_ISO])
        else $error("isochronous error not flagged");

    a_iso_bad_code: assert property (eng.iso_bad_tcode
        |=> state_reg.flags[`TPS_FLG_ISO])
        else $error("illegal iso code not flagged");

    a_flush_gated: assert property (eng.buf0_err && !state_reg.flush_en
        |=> !buf0_flush && !$rose(state_reg.flags[`TPS_FLG_FLSH0]))
        else $error("flush without enable");

    a_flush_enabled: assert property (eng.buf0_err && state_reg.flush_en
        |=> buf0_flush && state_reg.flags[`TPS_FLG_FLSH0])
        else $error("enabled error flush not performed");

    a_flush_pulse: assert property (!eng.buf0_err |=> !buf0_flush)
        else $error("buffer flush without error");

    a_read_clears: assert property (rd_flags && sets == 32'h0
        |=> (state_reg.flags & $past(state_reg.rdata)) == 32'h0)
        else $error("flag read did not clear");

    a_wr_flags_clear: assert property (wr_flags && sets == 32'h0
        |=> (state_reg.flags & $past(avs_req.writedata & bmask)) == 32'h0)
        else $error("written one did not clear its flag");

    a_flags_sticky: assert property (!rd_flags && !wr_flags
        |=> (state_reg.flags & $past(state_reg.flags)) == $past(state_reg.flags))
        else $error("flag cleared without software access");

    a_event_wins: assert property (rd_flags && eng.ack_valid
        |=> state_reg.flags[`TPS_FLG_RCVD])
        else $error("new event lost to flag read");

    a_retry_limit: assert property (eng.retry
        && state_reg.retry_cnt == state_reg.retry_max
        |=> state_reg.flags[`TPS_FLG_ASY])
        else $error("retry exhaustion not flagged");

    a_retry_count: assert property (eng.retry && !eng.pkt_done
        && state_reg.retry_cnt != state_reg.retry_max
        |=> state_reg.retry_cnt == $past(state_reg.retry_cnt) + 8'h01)
        else $error("retry attempt not counted");

    a_retry_restart: assert property (eng.pkt_done |=> state_reg.retry_cnt == 8'h00)
        else $error("retry count not restarted by a packet");

    a_ack_flush: assert property (ack_flush |=> state_reg.ack_cnt == 3'h0)
        else $error("acknowledge flush did not empty");

    a_flush_reads_zero: assert property (!state_reg.waitreq && avs_req.read
        && avs_req.address == `TPS_OFF_CTRL |-> avs_readdata[`TPS_CTRL_FLUSH] == 1'b0)
        else $error("acknowledge flush bit reads back one");

    a_bus_one_wait: assert property ((avs_req.read || avs_req.write) && avs_waitrequest
        |=> !avs_waitrequest)
        else $error("request not answered after one wait cycle");

    a_answer_one_cycle: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");

    a_idle_waits: assert property (!avs_req.read && !avs_req.write |=> avs_waitrequest)
        else $error("answer without a request");

endmodule : tps_tx_status

// ==== tb/tps_ack_partner.sv ====
`timescale 1ns/1ns
// Remote node: answers each send of nonzero delay with one acknowledge after that delay, unless another send comes first and restarts the wait
module tps_ack_partner (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Request from bench
    input wire logic send,
    input wire logic [3:0] code,
    input wire logic [4:0] delay,
    // Acknowledge towards the link
    output logic ack_valid,
    output logic [3:0] ack_code
);
    logic [4:0] wait_reg;
    logic [3:0] code_reg;
    always @(posedge clk) begin
        ack_valid <= 1'b0;
        // Code not held outside the pulse
        ack_code <= ~ack_code;
        if (reset) begin
            wait_reg <= 5'h00;
            ack_code <= 4'h0;
        end else if (send) begin
            wait_reg <= delay;
            code_reg <= code;
        end else if (wait_reg != 5'h00) begin
            wait_reg <= wait_reg - 5'h01;
            if (wait_reg == 5'h01) begin
                ack_valid <= 1'b1;
                ack_code <= code_reg;
            end
        end
    end
endmodule : tps_ack_partner

// ==== tb/tx_path_status_events_bench.sv ====
`timescale 1ns/1ns
module tx_path_status_events_bench;
    localparam logic [31:0] F_ASY = 32'h08000000, F_LOST = 32'h04000000,
        F_RCVD = 32'h02000000, F_ISO = 32'h01000000, F_FL0 = 32'h00800000;
    localparam logic [6:0] E_POP = 7'h40, E_DONE = 7'h20, E_RTY = 7'h10,
        E_BAD = 7'h08, E_ISOT = 7'h04, E_ISOL = 7'h02, E_BUF = 7'h01;
    localparam logic [7:0] VA [4] = '{8'h01, 8'h03, 8'h01, 8'h10};
    localparam logic [7:0] VB [4] = '{8'h01, 8'h04, 8'h02, 8'h00};
    localparam logic [3:0] VE = 4'h3;
    logic clk = 1'b0;
    logic reset = 1'b1;
    tps_pkg::tps_avs_req_t req = '0;
    tps_pkg::tps_engine_t eng_b = '0;
    tps_pkg::tps_engine_t eng_all;
    logic [6:0] pulse = 7'h00;
    logic [31:0] rdata;
    logic waitreq, buf0_flush, irq, p_valid;
    logic p_send = 1'b0;
    logic [3:0] p_code = 4'h0;
    logic [3:0] p_ack;
    logic [4:0] p_delay = 5'h01;
    logic [31:0] exp_q[$], msk_q[$];
    int miscompares = 0, comparisons = 0, cycles = 0;
    always #4 clk = ~clk;
    always_comb begin
        eng_all = eng_b;
        eng_all.ack_valid = p_valid;
        eng_all.ack_code = p_ack;
        {eng_all.ack_pop, eng_all.pkt_done, eng_all.retry, eng_all.async_bad_tcode,
            eng_all.iso_bad_tcode, eng_all.iso_len_err, eng_all.buf0_err} = pulse;
    end
    tps_tx_status #(.ACK_DEPTH(7)) dut (.clk(clk), .reset(reset), .avs_req(req),
        .avs_readdata(rdata), .avs_waitrequest(waitreq), .eng(eng_all),
        .buf0_flush(buf0_flush), .irq(irq));
    tps_ack_partner partner (.clk(clk), .reset(reset), .send(p_send), .code(p_code),
        .delay(p_delay), .ack_valid(p_valid), .ack_code(p_ack));
    task automatic report_and_stop();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : report_and_stop
    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", n, exp, seen);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        req.address <= a;
        req.read <= ~w;
        req.write <= w;
        req.writedata <= d;
        req.byteenable <= 4'hF;
        do @(posedge clk); while (waitreq);
        req.read <= 1'b0;
        req.write <= 1'b0;
        @(posedge clk);
    endtask : bus
    task automatic rd(input logic [11:0] a, input logic [31:0] e,
        input logic [31:0] m = 32'hFFFFFFFF);
        exp_q.push_back(e & m);
        msk_q.push_back(m);
        bus(1'b0, a, 32'h0);
    endtask : rd
    task automatic ev(input logic [6:0] p, input logic [31:0] q = 32'h0);
        pulse <= p;
        eng_b.pkt_quadlet <= q;
        @(posedge clk);
        pulse <= 7'h00;
        @(posedge clk);
    endtask : ev
    task automatic ack(input logic [3:0] c);
        p_code <= c;
        p_delay <= 5'h01 + 5'($urandom % 20);
        p_send <= 1'b1;
        @(posedge clk);
        p_send <= 1'b0;
        do @(posedge clk); while (!p_valid);
        @(posedge clk);
    endtask : ack
    function automatic logic [31:0] st(logic v, logic e, logic [3:0] c, logic [31:0] q,
        logic [2:0] n);
        return {2'b00, v, e, c, 2'b00, q[21:16], q[15:8], q[7:4], 1'b0, n};
    endfunction : st
    function automatic logic bad(logic [3:0] c);
        return !(c inside {4'h1, 4'h2, 4'h4, 4'h5, 4'h6});
    endfunction : bad
    // Read monitor: oldest note against data taken at the accept edge
    always @(posedge clk) begin
        if (req.read && !waitreq && exp_q.size() > 0)
            chk("readdata", rdata & msk_q.pop_front(), exp_q.pop_front());
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            report_and_stop();
        end
    end
    initial begin
        logic [31:0] q;
        logic [3:0] c;
        void'($urandom(32550));
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        repeat (2) @(posedge clk);
        rd(12'h240, 32'h000000FF);
        rd(12'h244, 32'h0);
        rd(12'h248, 32'h0);
        rd(12'h24C, 32'h0);
        rd(12'h250, 32'h0);
        rd(12'h2FC, 32'h0);
        bus(1'b1, 12'h244, 32'hFFFFFFFF);
        bus(1'b1, 12'h24C, 32'hFFFFFFFF);
        rd(12'h244, 32'h0);
        rd(12'h24C, 32'h0F800000);
        for (int i = 0; i < 16; i++) begin
            c = 4'(i);
            q = $urandom;
            q[21:16] = 6'($urandom % 63);
            q[7:4] = 4'($urandom % 10);
            ev(E_DONE, q);
            ack(c);
            chk("irq", {31'h0, irq}, 32'h1);
            rd(12'h244, st(1'b0, bad(c), c, q, 3'h1));
            rd(12'h248, F_RCVD | (bad(c) ? F_ASY : 32'h0));
            rd(12'h248, 32'h0);
            chk("irq", {31'h0, irq}, 32'h0);
            ev(E_POP);
        end
        for (int i = 0; i < 8; i++) ack(4'h1);
        rd(12'h244, 32'h7, 32'h7);
        rd(12'h248, F_LOST, F_LOST);
        bus(1'b1, 12'h240, 32'h000100FF);
        rd(12'h244, 32'h0, 32'h7);
        rd(12'h240, 32'h000000FF);
        q = $urandom;
        q[7:4] = 4'hA;
        ev(E_DONE, q);
        rd(12'h244, st(1'b0, 1'b0, 4'h1, q, 3'h1), 32'hFFC0FFFF);
        q = $urandom;
        q[21:16] = 6'h3F;
        q[7:4] = 4'h0;
        ev(E_DONE, q);
        rd(12'h244, st(1'b0, 1'b0, 4'h1, q, 3'h2));
        rd(12'h248, F_RCVD);
        bus(1'b1, 12'h240, 32'h00000002);
        ev(E_RTY);
        ev(E_RTY);
        rd(12'h248, 32'h0);
        ev(E_RTY);
        rd(12'h248, F_ASY);
        ev(E_BAD);
        rd(12'h248, F_ASY);
        ev(E_ISOT);
        rd(12'h248, F_ISO);
        ev(E_ISOL);
        bus(1'b1, 12'h248, F_ISO);
        rd(12'h248, 32'h0);
        ev(E_BUF);
        chk("buf0_flush", {31'h0, buf0_flush}, 32'h0);
        rd(12'h248, 32'h0);
        bus(1'b1, 12'h250, 32'h00000001);
        ev(E_BUF);
        chk("buf0_flush", {31'h0, buf0_flush}, 32'h1);
        rd(12'h248, F_FL0);
        for (int i = 0; i < 4; i++) begin
            eng_b.vid_a_sel <= VA[i];
            eng_b.vid_b_sel <= VB[i];
            repeat (2) @(posedge clk);
            rd(12'h244, {2'b00, VE[i], 29'h0}, 32'h20000000);
        end
        bus(1'b1, 12'h24C, 32'h0);
        ack(4'h1);
        chk("irq", {31'h0, irq}, 32'h0);
        rd(12'h248, F_RCVD);
        // Mid-run reset: count, limit and enables return to their reset values
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        repeat (2) @(posedge clk);
        rd(12'h240, 32'h000000FF);
        rd(12'h244, 32'h0);
        rd(12'h250, 32'h0);
        chk("irq", {31'h0, irq}, 32'h0);
        report_and_stop();
    end
endmodule : tx_path_status_events_bench
